// [hw/tca_consts.svh]
`ifndef TCA_CONSTS_SVH
`define TCA_CONSTS_SVH

// Register indices; the byte address of each register is four times its index.
`define TCA_IDX_CTL0     10'h051
`define TCA_IDX_CTL1     10'h081
`define TCA_IDX_CTL2     10'h0b1
`define TCA_IDX_CTL3     10'h0e1
`define TCA_IDX_GQUAL    10'h0f4
`define TCA_IDX_PQUAL0   10'h0f8
`define TCA_IDX_STAT     10'h0fc

// Per-port control register fields.
`define TCA_BIT_RDI      7
`define TCA_BIT_ODI      6
`define TCA_BIT_AIS      5
`define TCA_BIT_EN       4
`define TCA_BIT_RE       3
`define TCA_BIT_OE       2
`define TCA_CTL_MASK     8'hfc
`define TCA_CTL_RST      8'h00

// Per-port qualifier register fields.
`define TCA_PQ_TTAIS     0
`define TCA_PQ_SIZE      1
`define TCA_PQ_RST       2'h0

// Global qualifier register fields.
`define TCA_GQ_DBAIS     0
`define TCA_GQ_V1SEL     1
`define TCA_GQ_UNEQ      2
`define TCA_GQ_RST       3'h0

// Timing: clock rate, sampling multiframe and tandem multiframe.
`define TCA_CLK_MHZ      50
`define TCA_MF_US        500
`define TCA_TCMF_MS      38
`define TCA_MF_CYC       (`TCA_MF_US * `TCA_CLK_MHZ)
`define TCA_MF_PER_TCMF  ((`TCA_TCMF_MS * 1000) / `TCA_MF_US)

`endif

// [hw/tca_pkg.sv]
package tca_pkg;

   // Positions of the per-bus alarms inside an alarm vector.
   typedef enum int unsigned {
      TCA_ALM_PTR_LOSS   = 0,
      TCA_ALM_TU_AIS     = 1,
      TCA_ALM_LBL_UNEQ   = 2,
      TCA_ALM_LBL_MISM   = 3,
      TCA_ALM_TT_LOL     = 4,
      TCA_ALM_TT_MISM    = 5,
      TCA_ALM_TC_UNEQ    = 6,
      TCA_ALM_TC_LOL     = 7,
      TCA_ALM_TC_MISM    = 8,
      TCA_ALM_TC_LOM     = 9
   } tca_alarm_e_t;

   typedef logic [9:0] tca_alarm_vec_t;

endpackage

// [hw/tca_port_ctl.sv]
`timescale 1ns/1ns
`default_nettype none
`include "tca_consts.svh"

module tca_port_ctl (
   input  wire logic clk_i,  // System clock.
   input  wire logic rst_i,  // Synchronous reset, active high.
   tca_port_if.port  pif     // Control, alarms and results of one port.
);
   import tca_pkg::*;

   logic en, re, oe, f_rdi, f_odi;
   logic hit, cond_rdi, cond_odi, tc_any;
   logic pend_rdi_q, pend_rdi_d, pend_odi_q, pend_odi_d;
   logic rdi_q, rdi_d, odi_q, odi_d, ais_q, ais_d, en_q, rx_q, rx_d;

   assign en    = pif.ctl[`TCA_BIT_EN];
   assign re    = pif.ctl[`TCA_BIT_RE];
   assign oe    = pif.ctl[`TCA_BIT_OE];
   assign f_rdi = pif.ctl[`TCA_BIT_RDI];
   assign f_odi = pif.ctl[`TCA_BIT_ODI];

   always_comb begin
      tca_alarm_vec_t v;
      v      = '0;
      hit    = 1'b0;
      tc_any = 1'b0;
      for (int b = 0; b < 2; b++) begin
         v = (b == 0) ? pif.al_a : pif.al_b;
         hit = hit | v[TCA_ALM_PTR_LOSS] | v[TCA_ALM_TU_AIS] | v[TCA_ALM_LBL_MISM]
               | v[TCA_ALM_TC_UNEQ] | v[TCA_ALM_TC_LOL] | v[TCA_ALM_TC_MISM]
               | v[TCA_ALM_TC_LOM];
         hit = hit | (pif.db_ais[b] & pif.gqual[`TCA_GQ_DBAIS])
               | (pif.db_h4[b] & pif.gqual[`TCA_GQ_V1SEL])
               | (v[TCA_ALM_LBL_UNEQ] & pif.gqual[`TCA_GQ_UNEQ])
               | ((v[TCA_ALM_TT_LOL] | v[TCA_ALM_TT_MISM]) & pif.pqual[`TCA_PQ_TTAIS]);
         tc_any = tc_any | v[TCA_ALM_TC_UNEQ] | v[TCA_ALM_TC_LOL] | v[TCA_ALM_TC_MISM]
                  | v[TCA_ALM_TC_LOM];
      end
   end

   assign cond_rdi = en & (f_rdi | (re & hit));
   assign cond_odi = en & (f_odi | (oe & hit));

   always_comb begin
      pend_rdi_d = pend_rdi_q;
      pend_odi_d = pend_odi_q;
      rdi_d      = rdi_q;
      odi_d      = odi_q;
      if (pif.tick_mf) begin
         pend_rdi_d = pend_rdi_q | cond_rdi;
         pend_odi_d = pend_odi_q | cond_odi;
      end
      if (pif.tick_tcmf) begin
         rdi_d      = pend_rdi_q | cond_rdi;
         odi_d      = pend_odi_q | cond_odi;
         pend_rdi_d = 1'b0;
         pend_odi_d = 1'b0;
      end
      if (!en) begin
         rdi_d      = 1'b0;
         odi_d      = 1'b0;
         pend_rdi_d = 1'b0;
         pend_odi_d = 1'b0;
      end
      ais_d = en & pif.ctl[`TCA_BIT_AIS];
      rx_d  = en & tc_any;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_rdi_q <= 1'b0;
         pend_odi_q <= 1'b0;
         rdi_q      <= 1'b0;
         odi_q      <= 1'b0;
         ais_q      <= 1'b0;
         en_q       <= 1'b0;
         rx_q       <= 1'b0;
      end else begin
         pend_rdi_q <= pend_rdi_d;
         pend_odi_q <= pend_odi_d;
         rdi_q      <= rdi_d;
         odi_q      <= odi_d;
         ais_q      <= ais_d;
         en_q       <= en;
         rx_q       <= rx_d;
      end
   end

   assign pif.rdi_bit     = rdi_q;
   assign pif.odi_bit     = odi_q;
   assign pif.ais_bit     = ais_q;
   assign pif.tc_on       = en_q;
   assign pif.pend_rdi    = pend_rdi_q;
   assign pif.pend_odi    = pend_odi_q;
   assign pif.rx_tc_alarm = rx_q;

   property p_rdi_force;
      @(posedge clk_i) disable iff (rst_i)
      pif.tick_tcmf && en && f_rdi |=> rdi_q;
   endproperty
   a_rdi_force: assert property (p_rdi_force) else $error("forced remote defect not sent");

   property p_odi_force;
      @(posedge clk_i) disable iff (rst_i)
      pif.tick_tcmf && en && f_odi |=> odi_q;
   endproperty
   a_odi_force: assert property (p_odi_force) else $error("forced outgoing defect not sent");

   property p_ais;
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> ais_q == ($past(en) && $past(pif.ctl[`TCA_BIT_AIS]));
   endproperty
   a_ais: assert property (p_ais) else $error("N2 AIS bit does not follow control");

   property p_rx_off;
      @(posedge clk_i) disable iff (rst_i)
      !en |=> !rx_q;
   endproperty
   a_rx_off: assert property (p_rx_off) else $error("receive TC alarm while disabled");

   property p_off_zero;
      @(posedge clk_i) disable iff (rst_i)
      !en |=> !rdi_q && !odi_q && !ais_q && !en_q;
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("TC bits not zero while disabled");

   property p_auto_rdi;
      @(posedge clk_i) disable iff (rst_i)
      pif.tick_tcmf && en && re && (pif.al_a[TCA_ALM_PTR_LOSS] || pif.al_b[TCA_ALM_TC_LOM])
      |=> rdi_q;
   endproperty
   a_auto_rdi: assert property (p_auto_rdi) else $error("alarm did not raise remote defect");

   property p_qual_off;
      @(posedge clk_i) disable iff (rst_i)
      pif.tick_tcmf && en && !f_rdi && !pend_rdi_q && pif.gqual == 3'h0
      && pif.pqual[`TCA_PQ_TTAIS] == 1'b0 && pif.al_a == 10'h034 && pif.al_b == 10'h000
      |=> !rdi_q;
   endproperty
   a_qual_off: assert property (p_qual_off) else $error("unqualified alarm raised defect");

   property p_no_auto;
      @(posedge clk_i) disable iff (rst_i)
      pif.tick_tcmf && en && !re && !f_rdi && !pend_rdi_q |=> !rdi_q;
   endproperty
   a_no_auto: assert property (p_no_auto) else $error("remote defect without force");

   property p_hold;
      @(posedge clk_i) disable iff (rst_i)
      !pif.tick_tcmf && en |=> rdi_q == $past(rdi_q) && odi_q == $past(odi_q);
   endproperty
   a_hold: assert property (p_hold) else $error("defect bit changed mid multiframe");

   property p_sample;
      @(posedge clk_i) disable iff (rst_i)
      pif.tick_mf && !pif.tick_tcmf && cond_rdi ##1 en |-> pend_rdi_q;
   endproperty
   a_sample: assert property (p_sample) else $error("sampled alarm not held pending");

   property p_auto_odi;
      @(posedge clk_i) disable iff (rst_i)
      pif.tick_tcmf && en && oe && hit |=> odi_q;
   endproperty
   a_auto_odi: assert property (p_auto_odi) else $error("alarm did not raise outgoing defect");

   property p_clear;
      @(posedge clk_i) disable iff (rst_i)
      pif.tick_tcmf |=> !pend_rdi_q && !pend_odi_q;
   endproperty
   a_clear: assert property (p_clear) else $error("pending not cleared after commit");

endmodule // tca_port_ctl

`default_nettype wire

// [hw/tca_port_if.sv]
`timescale 1ns/1ns
`default_nettype none

interface tca_port_if;
   logic [7:0]              ctl;
   logic [1:0]              pqual;
   logic [2:0]              gqual;
   tca_pkg::tca_alarm_vec_t al_a;
   tca_pkg::tca_alarm_vec_t al_b;
   logic [1:0]              db_ais;
   logic [1:0]              db_h4;
   logic                    tick_mf;
   logic                    tick_tcmf;
   logic                    rdi_bit;
   logic                    odi_bit;
   logic                    ais_bit;
   logic                    tc_on;
   logic                    pend_rdi;
   logic                    pend_odi;
   logic                    rx_tc_alarm;

   modport top (output ctl, pqual, gqual, al_a, al_b, db_ais, db_h4, tick_mf, tick_tcmf,
                input rdi_bit, odi_bit, ais_bit, tc_on, pend_rdi, pend_odi, rx_tc_alarm);
   modport port (input ctl, pqual, gqual, al_a, al_b, db_ais, db_h4, tick_mf, tick_tcmf,
                 output rdi_bit, odi_bit, ais_bit, tc_on, pend_rdi, pend_odi, rx_tc_alarm);
endinterface // tca_port_if

`default_nettype wire

// [hw/tca_top.sv]
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "tca_consts.svh"

module tca_top #(
   parameter int unsigned MF_CYC      = `TCA_MF_CYC,      // Clocks per 500 us multiframe.
   parameter int unsigned MF_PER_TCMF = `TCA_MF_PER_TCMF  // Multiframes per TC multiframe.
) (
   input  wire logic                            clk_i,           // System clock, 50 MHz.
   input  wire logic                            rst_i,           // Synchronous reset.
   input  wire logic                            psel_i,          // APB select.
   input  wire logic                            penable_i,       // APB enable.
   input  wire logic                            pwrite_i,        // APB direction.
   input  wire logic [11:0]                     paddr_i,         // APB byte address.
   input  wire logic [31:0]                     pwdata_i,        // APB write data.
   output logic [31:0]                          prdata_o,        // APB read data.
   output logic                                 pready_o,        // APB ready.
   output logic                                 pslverr_o,       // APB error.
   input  wire tca_pkg::tca_alarm_vec_t [3:0]   alarms_a_i,      // Drop bus A alarms.
   input  wire tca_pkg::tca_alarm_vec_t [3:0]   alarms_b_i,      // Drop bus B alarms.
   input  wire logic [1:0]                      drop_bus_upstream_ais_i, // Upstream AIS.
   input  wire logic [1:0]                      drop_bus_h4_error_i,     // H4 error.
   output logic [3:0]                           tc_frame73_bit8_o,  // Remote defect bit.
   output logic [3:0]                           tc_frame74_bit7_o,  // Outgoing defect bit.
   output logic [3:0]                           n2_bit4_ais_o,      // N2 AIS bit.
   output logic [3:0]                           n2_tc_bits_en_o,    // N2 bits 3..8 live.
   output logic [3:0]                           rx_tc_alarm_o,      // Gated receive alarm.
   output logic                                 tcmf_start_o        // TC multiframe tick.
);
   import tca_pkg::*;

   localparam int unsigned NP = 4;
   localparam int unsigned MW = $clog2(MF_CYC + 1);
   localparam int unsigned TW = $clog2(MF_PER_TCMF + 1);
   localparam int unsigned SW = 2 * NP * 10 + 4;

   // Raw alarms are pins from the drop bus side; two stages before use.
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   logic [SW-1:0] raw;

   assign raw = {drop_bus_h4_error_i, drop_bus_upstream_ais_i, alarms_b_i, alarms_a_i};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= raw;
         sync2_q <= sync1_q;
      end
   end

   // Multiframe timers.
   logic [MW-1:0] mf_cnt_q;
   logic [MW-1:0] mf_cnt_d;
   logic [TW-1:0] tc_cnt_q;
   logic [TW-1:0] tc_cnt_d;
   logic          tick_mf;
   logic          tick_tcmf;
   logic          tick_tcmf_q;

   assign tick_mf   = (mf_cnt_q == MW'(MF_CYC - 1));
   assign tick_tcmf = tick_mf && (tc_cnt_q == TW'(MF_PER_TCMF - 1));

   always_comb begin
      mf_cnt_d = tick_mf ? '0 : mf_cnt_q + MW'(1);
      tc_cnt_d = tc_cnt_q;
      if (tick_mf) begin
         tc_cnt_d = tick_tcmf ? '0 : tc_cnt_q + TW'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mf_cnt_q    <= '0;
         tc_cnt_q    <= '0;
         tick_tcmf_q <= 1'b0;
      end else begin
         mf_cnt_q    <= mf_cnt_d;
         tc_cnt_q    <= tc_cnt_d;
         tick_tcmf_q <= tick_tcmf;
      end
   end

   assign tcmf_start_o = tick_tcmf_q;

   // Register file.
   logic [7:0] ctl_q [NP];
   logic [7:0] ctl_d [NP];
   logic [1:0] pq_q  [NP];
   logic [1:0] pq_d  [NP];
   logic [2:0] gq_q;
   logic [2:0] gq_d;
   logic [3:0] st_rdi;
   logic [3:0] st_odi;
   logic [3:0] st_prdi;
   logic [3:0] st_podi;

   function automatic logic [9:0] ctl_idx(input int unsigned p);
      logic [9:0] r;
      r = `TCA_IDX_CTL0;
      case (p)
         1: r = `TCA_IDX_CTL1;
         2: r = `TCA_IDX_CTL2;
         3: r = `TCA_IDX_CTL3;
         default: r = `TCA_IDX_CTL0;
      endcase
      return r;
   endfunction

   logic [9:0]  idx;
   logic        setup;
   logic        access;
   logic        wr_en;
   logic        miss_d;
   logic        miss_q;
   logic [31:0] rd_d;
   logic [31:0] rd_q;

   assign idx    = paddr_i[11:2];
   assign setup  = psel_i && !penable_i;
   assign access = psel_i && penable_i;
   assign wr_en  = access && pwrite_i && !miss_q;

   // Decode in the setup cycle so the read word comes from a flop.
   always_comb begin
      miss_d = 1'b1;
      rd_d   = 32'h0000_0000;
      for (int p = 0; p < NP; p++) begin
         if (idx == ctl_idx(p)) begin
            miss_d = 1'b0;
            rd_d   = {24'h00_0000, ctl_q[p]};
         end
         if (idx == `TCA_IDX_PQUAL0 + 10'(p)) begin
            miss_d = 1'b0;
            rd_d   = {30'h0000_0000, pq_q[p]};
         end
      end
      if (idx == `TCA_IDX_GQUAL) begin
         miss_d = 1'b0;
         rd_d   = {29'h0000_0000, gq_q};
      end
      if (idx == `TCA_IDX_STAT) begin
         miss_d = 1'b0;
         rd_d   = {16'h0000, st_podi, st_prdi, st_odi, st_rdi};
      end
   end

   always_comb begin
      gq_d = gq_q;
      for (int p = 0; p < NP; p++) begin
         ctl_d[p] = ctl_q[p];
         pq_d[p]  = pq_q[p];
         if (wr_en && idx == ctl_idx(p)) begin
            ctl_d[p] = pwdata_i[7:0] & `TCA_CTL_MASK;
         end
         if (wr_en && idx == `TCA_IDX_PQUAL0 + 10'(p)) begin
            pq_d[p] = pwdata_i[1:0];
         end
      end
      if (wr_en && idx == `TCA_IDX_GQUAL) begin
         gq_d = pwdata_i[2:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gq_q   <= `TCA_GQ_RST;
         miss_q <= 1'b0;
         rd_q   <= 32'h0000_0000;
         for (int p = 0; p < NP; p++) begin
            ctl_q[p] <= `TCA_CTL_RST;
            pq_q[p]  <= `TCA_PQ_RST;
         end
      end else begin
         gq_q <= gq_d;
         for (int p = 0; p < NP; p++) begin
            ctl_q[p] <= ctl_d[p];
            pq_q[p]  <= pq_d[p];
         end
         if (setup) begin
            miss_q <= miss_d;
            rd_q   <= rd_d;
         end
      end
   end

   // Zero wait states: the access cycle always completes.
   assign pready_o  = access;
   assign pslverr_o = access && miss_q;
   assign prdata_o  = rd_q;

   // Per-port defect engines.
   for (genvar gp = 0; gp < NP; gp++) begin : g_port
      tca_port_if pif ();

      assign pif.ctl       = ctl_q[gp];
      assign pif.pqual     = pq_q[gp];
      assign pif.gqual     = gq_q;
      assign pif.al_a      = sync2_q[gp*10 +: 10];
      assign pif.al_b      = sync2_q[NP*10 + gp*10 +: 10];
      assign pif.db_ais    = sync2_q[2*NP*10 +: 2];
      assign pif.db_h4     = sync2_q[2*NP*10 + 2 +: 2];
      assign pif.tick_mf   = tick_mf;
      assign pif.tick_tcmf = tick_tcmf;

      tca_port_ctl u_port (
         .clk_i (clk_i),
         .rst_i (rst_i),
         .pif   (pif.port)
      );

      assign tc_frame73_bit8_o[gp] = pif.rdi_bit;
      assign tc_frame74_bit7_o[gp] = pif.odi_bit;
      assign n2_bit4_ais_o[gp]     = pif.ais_bit;
      assign n2_tc_bits_en_o[gp]   = pif.tc_on;
      assign rx_tc_alarm_o[gp]     = pif.rx_tc_alarm;
      assign st_rdi[gp]            = pif.rdi_bit;
      assign st_odi[gp]            = pif.odi_bit;
      assign st_prdi[gp]           = pif.pend_rdi;
      assign st_podi[gp]           = pif.pend_odi;
   end

   logic [TW-1:0] tc_gap_q;

   // Helper counter of multiframe ticks since the last TC commit.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tc_gap_q <= '0;
      end else if (tick_tcmf) begin
         tc_gap_q <= '0;
      end else if (tick_mf) begin
         tc_gap_q <= tc_gap_q + TW'(1);
      end
   end

   property p_tcmf_period;
      @(posedge clk_i) disable iff (rst_i)
      tick_tcmf |-> tick_mf && (tc_gap_q == TW'(MF_PER_TCMF - 1));
   endproperty
   a_tcmf_period: assert property (p_tcmf_period) else $error("TC multiframe period wrong");

   property p_mf_reload;
      @(posedge clk_i) disable iff (rst_i)
      tick_mf |=> mf_cnt_q == '0 && !tick_mf;
   endproperty
   a_mf_reload: assert property (p_mf_reload) else $error("multiframe timer did not reload");

   property p_ctl_write;
      @(posedge clk_i) disable iff (rst_i)
      wr_en && idx == `TCA_IDX_CTL0 |=> ctl_q[0] == ($past(pwdata_i[7:0]) & `TCA_CTL_MASK);
   endproperty
   a_ctl_write: assert property (p_ctl_write) else $error("control write not stored");

endmodule // tca_top

`default_nettype wire

// [verification/tca_add_bus_model.sv]
`timescale 1ns/1ns
`default_nettype none

module tca_add_bus_model (
   input  wire logic       clk_i,    // System clock.
   input  wire logic       rst_i,    // Synchronous reset.
   input  wire logic       tcmf_i,   // TC multiframe start pulse.
   input  wire logic [3:0] rdi_i,    // Frame 73 bit 8 per port.
   input  wire logic [3:0] odi_i,    // Frame 74 bit 7 per port.
   output var  logic [3:0] rdi_o,    // Remote defect as received.
   output var  logic [3:0] odi_o,    // Outgoing defect as received.
   output var  int         frames_o  // TC multiframes received.
);
   // The far end reads the bits only once per TC multiframe, so any glitch between frames
   // is invisible to it, just as on the real add bus.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdi_o    <= 4'h0;
         odi_o    <= 4'h0;
         frames_o <= 0;
      end else if (tcmf_i) begin
         rdi_o    <= rdi_i;
         odi_o    <= odi_i;
         frames_o <= frames_o + 1;
      end
   end
endmodule // tca_add_bus_model

`default_nettype wire

// [verification/tca_top_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "tca_consts.svh"

module tca_top_tb;
   import tca_pkg::*;
   localparam logic [9:0] cidx [4] = '{`TCA_IDX_CTL0, `TCA_IDX_CTL1, `TCA_IDX_CTL2,
                                        `TCA_IDX_CTL3};
   logic                 clk_i, rst_i, psel, penable, pwrite, pslverr, pready, tcmf;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata, r;
   tca_alarm_vec_t [3:0] al_a, al_b;
   tca_alarm_vec_t       ra, rb;
   logic [1:0]           ua, h4, ru, rh, rq;
   logic [2:0]           rg;
   logic [7:0]           rc;
   logic [3:0]           f73, f74, n2ais, n2en, rxal, m_rdi, m_odi;
   logic                 e;
   int                   frames, errors, checked, k, p;

   tca_top #(.MF_CYC(8), .MF_PER_TCMF(4)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .alarms_a_i(al_a), .alarms_b_i(al_b),
      .drop_bus_upstream_ais_i(ua), .drop_bus_h4_error_i(h4), .tc_frame73_bit8_o(f73),
      .tc_frame74_bit7_o(f74), .n2_bit4_ais_o(n2ais), .n2_tc_bits_en_o(n2en),
      .rx_tc_alarm_o(rxal), .tcmf_start_o(tcmf));

   tca_add_bus_model model_u (
      .clk_i(clk_i), .rst_i(rst_i), .tcmf_i(tcmf), .rdi_i(f73), .odi_i(f74),
      .rdi_o(m_rdi), .odi_o(m_odi), .frames_o(frames));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic mism(input string msg);
      errors++;
      $display("ERROR %0t %s", $time, msg);
   endtask

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) mism($sformatf("register got %h want %h", got, exp));
   endtask

   task automatic chk_bits(input logic [3:0] got, input logic [3:0] exp, input string what);
      checked++;
      if (got !== exp) mism($sformatf("%s got %b want %b", what, got, exp));
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge clk_i);
         if (pready === 1'b1) break;
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (i == 16) begin
         mism("no ready");
         complete_run();
      end
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk_reg(r, exp);
      chk_reg({31'h0, e}, 32'h0);
   endtask

   task automatic wait_frames(input int n);
      int t;
      int i;
      t = frames + n;
      for (i = 0; i < 200 * n; i++) begin
         @(posedge clk_i);
         if (frames >= t) break;
      end
      if (frames < t) begin
         mism("no TC multiframe");
         complete_run();
      end
      @(negedge clk_i);
   endtask

   function automatic logic exp_def(input logic en, f, au, input tca_alarm_vec_t a, b,
                                    input logic [1:0] u, hh, input logic [2:0] gq,
                                    input logic tq);
      tca_alarm_vec_t o;
      logic           hit;
      o   = a | b;
      hit = |(o & 10'h3cb) | (gq[2] & o[2]) | (tq & |o[5:4]) | (gq[0] & |u) | (gq[1] & |hh);
      return en & (f | (au & hit));
   endfunction

   // Only the chosen port is enabled, so the shared drop-bus inputs touch no other port.
   task automatic scen(input int pt, input logic [7:0] c, input logic [2:0] gq,
                       input logic [1:0] pq, input tca_alarm_vec_t a, b,
                       input logic [1:0] u, hh);
      logic [3:0]           er, eo, ea, ee, ex;
      tca_alarm_vec_t [3:0] va, vb;
      logic                 en;
      for (int i = 0; i < 4; i++) apb(1'b1, {cidx[i], 2'b00}, {24'h00_0000, (i == pt) ? c : 8'h00});
      apb(1'b1, {`TCA_IDX_GQUAL, 2'b00}, {29'h0000_0000, gq});
      apb(1'b1, {10'(`TCA_IDX_PQUAL0 + pt), 2'b00}, {30'h0000_0000, pq});
      va = '0;
      vb = '0;
      va[pt] = a;
      vb[pt] = b;
      al_a <= va;
      al_b <= vb;
      ua   <= u;
      h4   <= hh;
      wait_frames(2);
      en = c[`TCA_BIT_EN];
      {er, eo, ea, ee, ex} = '0;
      er[pt] = exp_def(en, c[`TCA_BIT_RDI], c[`TCA_BIT_RE], a, b, u, hh, gq, pq[0]);
      eo[pt] = exp_def(en, c[`TCA_BIT_ODI], c[`TCA_BIT_OE], a, b, u, hh, gq, pq[0]);
      ea[pt] = en & c[`TCA_BIT_AIS];
      ee[pt] = en;
      ex[pt] = en & |{a[9:6], b[9:6]};
      chk_bits(f73, er, "remote bit");
      chk_bits(m_rdi, er, "far end remote");
      chk_bits(m_odi, eo, "far end outgoing");
      chk_bits(n2ais, ea, "n2 ais");
      chk_bits(n2en, ee, "n2 live");
      chk_bits(rxal, ex, "rx alarm");
      $display("test port %0d ctl %h done", pt, c);
   endtask

   initial begin
      {rst_i, psel, penable, pwrite, paddr, pwdata, al_a, al_b, ua, h4} = '0;
      {errors, checked} = '0;
      rst_i = 1'b1;
      void'($urandom(32'hf978a890));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      for (k = 0; k < 4; k++) rd({cidx[k], 2'b00}, 32'h0);
      rd({`TCA_IDX_GQUAL, 2'b00}, 32'h0);
      rd({`TCA_IDX_STAT, 2'b00}, 32'h0);
      apb(1'b1, {cidx[2], 2'b00}, 32'hffffffff);
      rd({cidx[2], 2'b00}, 32'h000000fc);
      apb(1'b0, 12'h000, 32'h0);
      chk_reg({r[30:0], e}, 32'h1);
      $display("test registers done");
      scen(0, 8'h90, 3'h0, 2'h0, '0, '0, 2'h0, 2'h0);
      scen(1, 8'h50, 3'h0, 2'h0, '0, '0, 2'h0, 2'h0);
      scen(2, 8'h30, 3'h0, 2'h0, '0, '0, 2'h0, 2'h0);
      scen(3, 8'he0, 3'h7, 2'h1, 10'h3ff, 10'h3ff, 2'h3, 2'h3);
      scen(0, 8'h1c, 3'h0, 2'h0, 10'h034, '0, 2'h1, 2'h2);
      scen(1, 8'h1c, 3'h7, 2'h1, '0, 10'h010, 2'h2, 2'h0);
      scen(2, 8'h10, 3'h7, 2'h1, 10'h3ff, 10'h3ff, 2'h3, 2'h3);
      scen(3, 8'h18, 3'h0, 2'h0, 10'h001, '0, 2'h0, 2'h0);
      scen(1, 8'h14, 3'h0, 2'h0, '0, 10'h200, 2'h0, 2'h0);
      scen(0, 8'h18, 3'h0, 2'h0, '0, '0, 2'h0, 2'h0);
      @(posedge clk_i);
      al_b[0] <= 10'h080;
      repeat (8) @(posedge clk_i);
      al_b[0] <= 10'h000;
      @(negedge clk_i);
      chk_bits(f73, 4'h0, "early commit");
      wait_frames(1);
      chk_bits(f73, 4'h1, "brief alarm");
      wait_frames(1);
      chk_bits(f73, 4'h0, "stale pending");
      $display("test brief alarm done");
      for (k = 0; k < 24; k++) begin
         p  = $urandom % 4;
         rc = (8'($urandom) & 8'h3c) | ((($urandom % 4) == 0) ? 8'hc0 : 8'h00);
         rg = 3'($urandom);
         rq = {1'b0, 1'($urandom)};
         ra = tca_alarm_vec_t'(32'h1 << ($urandom % 14));
         rb = tca_alarm_vec_t'(32'h1 << ($urandom % 14));
         ru = 2'($urandom);
         rh = 2'($urandom);
         scen(p, rc, rg, rq, ra, rb, ru, rh);
      end
      complete_run();
   end
endmodule // tca_top_tb

`default_nettype wire
